// ### apsc_pkg.sv
// package: constants and types for the axis pulse step control block
package apsc_pkg;
  // ----------------------------------------------------------------
  // general-purpose input functions
  // ----------------------------------------------------------------
  localparam int unsigned GP_WIDTH    = 8;
  localparam int unsigned FUNC_WIDTH  = 3;
  localparam logic [2:0] IN_FN_NONE   = 3'h0;
  localparam logic [2:0] IN_FN_DSW    = 3'h1;
  localparam logic [2:0] IN_FN_MOFF   = 3'h2;
  localparam logic [2:0] IN_FN_HWHEEL = 3'h3;
  localparam logic [2:0] IN_FN_ABS    = 3'h4;
  localparam logic [2:0] IN_FN_STEP   = 3'h5;
  // ----------------------------------------------------------------
  // general-purpose output functions
  // ----------------------------------------------------------------
  localparam logic [2:0] OUT_FN_NONE  = 3'h0;
  localparam logic [2:0] OUT_FN_DIGIT = 3'h1;
  localparam logic [2:0] OUT_FN_READY = 3'h2;
  localparam logic [2:0] OUT_FN_MCODE = 3'h3;
  localparam logic [2:0] OUT_FN_ABS   = 3'h4;
  // ----------------------------------------------------------------
  // program line opcodes
  // ----------------------------------------------------------------
  localparam int unsigned OP_WIDTH = 2;
  localparam logic [1:0] OP_MOVE   = 2'h0;
  localparam logic [1:0] OP_M00    = 2'h1;
  localparam logic [1:0] OP_M02    = 2'h2;
  localparam logic [1:0] OP_NOP    = 2'h3;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned JOG_HOLD_MS    = 100;
  localparam int unsigned JOG_HOLD_CYC   = JOG_HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned PULSE_HALF_CYC = 100;
  localparam int unsigned CLR_PULSE_CYC  = 2000;
  localparam int unsigned CNT_WIDTH      = 32;
  localparam logic [31:0] CNT_ZERO       = 32'h0;
  localparam logic [31:0] CNT_ONE        = 32'h1;
  typedef enum logic [2:0] {
    APSC_IDLE  = 3'b000,
    APSC_FETCH = 3'b001,
    APSC_MOVE  = 3'b010,
    APSC_WAIT  = 3'b011,
    APSC_JOG   = 3'b100
  } apsc_state_e;
endpackage

// ### apsc_pulse_gen.sv
// module: one axis pulse generator with forward and reverse outputs
`timescale 1ns/10ps
`default_nettype none
module apsc_pulse_gen
  import apsc_pkg::*;
#(
  parameter int unsigned HALF_CYC = apsc_pkg::PULSE_HALF_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // request
  input  wire logic        req_valid,
  input  wire logic        req_dir_rev,
  input  wire logic [15:0] req_count,
  input  wire logic        abort,
  // status and pulses
  output logic             busy,
  output logic             forward_pulse_out,
  output logic             reverse_pulse_out
);
  logic [15:0] left_q;
  logic [31:0] tick_q;
  logic        dir_q;
  logic        phase_q;

  // ----------------------------------------------------------------
  // pulse sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      left_q  <= 16'h0000;
      tick_q  <= 32'h0;
      dir_q   <= 1'b0;
      phase_q <= 1'b0;
      busy    <= 1'b0;
    end else if (clk_en) begin
      if (abort) begin
        left_q  <= 16'h0000;
        phase_q <= 1'b0;
        busy    <= 1'b0;
      end else if (!busy && req_valid && req_count != 16'h0000) begin
        left_q  <= req_count;
        dir_q   <= req_dir_rev;
        tick_q  <= 32'h0;
        phase_q <= 1'b0;
        busy    <= 1'b1;
      end else if (busy) begin
        if (tick_q == HALF_CYC - 1) begin
          tick_q  <= 32'h0;
          phase_q <= ~phase_q;
          if (phase_q) begin
            left_q <= left_q - 16'h0001;
            if (left_q == 16'h0001) begin
              busy <= 1'b0;
            end
          end
        end else begin
          tick_q <= tick_q + 32'h1;
        end
      end
    end
  end

  // direction selects exactly one output, so both never rise together
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      forward_pulse_out <= 1'b0;
      reverse_pulse_out <= 1'b0;
    end else if (clk_en) begin
      forward_pulse_out <= busy && phase_q && !dir_q && !abort;
      reverse_pulse_out <= busy && phase_q && dir_q && !abort;
    end
  end
endmodule
`default_nettype wire

// ### apsc_axis_ctrl.sv
// module: two-axis step, start, stop and jog control with pulse outputs
//
// Overview of operation
// - a general input assigned the step function puts the unit in step mode
// - in step mode each start rising edge at idle runs exactly one program line
// - in step mode start edges are ignored until the current line completes
// - in dual-axis mode step, start, stop and m-off apply to both axes
// - a dedicated output tells the drive to clear its deviation counter
// - forward travel pulses leave on the forward pulse output
// - reverse travel pulses leave on the separate reverse pulse output
// - a zero marker input is accepted for reference detection
// - each of eight general inputs takes a configurable function
// - each of eight general outputs takes a configurable function
// - auto and ready: start runs pulses; stop, m00 or m02 clear start
// - stop rising edge halts; stop beats start and both jog inputs
// - jog gives one pulse, continuous pulses after 0.1 s held
`timescale 1ns/10ps
`default_nettype none
module apsc_axis_ctrl
  import apsc_pkg::*;
#(
  parameter int unsigned JOG_HOLD = apsc_pkg::JOG_HOLD_CYC,
  parameter int unsigned CLR_LEN  = apsc_pkg::CLR_PULSE_CYC
) (
  // clock, reset, enable
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     clk_en,
  // mode and commands, index 0 is x axis, 1 is y axis
  input  wire logic                     dual_axis,
  input  wire logic                     auto_mode,
  input  wire logic [1:0]               start_in,
  input  wire logic [1:0]               stop_in,
  input  wire logic [1:0]               jog_forward_in,
  input  wire logic [1:0]               jog_reverse_in,
  input  wire logic [1:0]               deviation_clear_req,
  // program line source
  input  wire logic [1:0][OP_WIDTH-1:0] line_op,
  input  wire logic [1:0]               line_dir_rev,
  input  wire logic [1:0][15:0]         line_count,
  output logic      [1:0]               line_advance,
  // drive side
  input  wire logic [1:0]               drive_ready_in,
  input  wire logic [1:0]               drive_in_position_in,
  input  wire logic [1:0]               zero_marker_in,
  output logic      [1:0]               deviation_clear_out,
  output logic      [1:0]               forward_pulse_out,
  output logic      [1:0]               reverse_pulse_out,
  // general purpose i/o and its function maps
  input  wire logic [GP_WIDTH-1:0]      general_inputs,
  input  wire logic [GP_WIDTH-1:0][FUNC_WIDTH-1:0] in_func,
  input  wire logic [GP_WIDTH-1:0][FUNC_WIDTH-1:0] out_func,
  input  wire logic [GP_WIDTH-1:0]      out_source,
  output logic      [GP_WIDTH-1:0]      general_outputs,
  // status
  output logic      [1:0]               step_mode,
  output logic      [1:0]               positioning_complete_flag,
  output logic      [1:0]               zero_seen,
  output logic      [1:0]               running,
  output logic      [1:0]               m_code_off,
  output logic      [GP_WIDTH-1:0]      switch_data,
  output logic      [GP_WIDTH-1:0]      hwheel_data,
  output logic      [GP_WIDTH-1:0]      absolute_position_data
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [GP_WIDTH-1:0] func_mask(
    input logic [GP_WIDTH-1:0][FUNC_WIDTH-1:0] map,
    input logic [FUNC_WIDTH-1:0] fn
  );
    logic [GP_WIDTH-1:0] m;
    m = '0;
    for (int i = 0; i < GP_WIDTH; i++) begin
      m[i] = (map[i] == fn);
    end
    return m;
  endfunction

  // merges a per-axis command onto both axes in dual-axis operation
  function automatic logic [1:0] share(input logic [1:0] v, input logic dual);
    return dual ? {2{|v}} : v;
  endfunction

  logic [1:0] start_q, stop_q, jf_q, jr_q;
  logic [1:0] start_rise, stop_rise, start_sh, stop_sh;
  logic [1:0] moff_sh, step_sh;
  logic       step_sel;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_q <= 2'h0;
      stop_q  <= 2'h0;
      jf_q    <= 2'h0;
      jr_q    <= 2'h0;
    end else if (clk_en) begin
      start_q <= start_in;
      stop_q  <= stop_in;
      jf_q    <= jog_forward_in;
      jr_q    <= jog_reverse_in;
    end
  end

  assign step_sel   = |(general_inputs & func_mask(in_func, IN_FN_STEP));
  assign start_rise = start_in & ~start_q;
  assign stop_rise  = stop_in & ~stop_q;
  assign start_sh   = share(start_rise, dual_axis);
  assign stop_sh    = share(stop_rise, dual_axis);
  assign step_sh    = {2{step_sel}};
  assign moff_sh    = {2{|(general_inputs & func_mask(in_func, IN_FN_MOFF))}};

  // ----------------------------------------------------------------
  // general-purpose input functions
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      switch_data            <= 8'h00;
      hwheel_data            <= 8'h00;
      absolute_position_data <= 8'h00;
      step_mode              <= 2'h0;
      m_code_off             <= 2'h0;
    end else if (clk_en) begin
      switch_data            <= general_inputs & func_mask(in_func, IN_FN_DSW);
      hwheel_data            <= general_inputs & func_mask(in_func, IN_FN_HWHEEL);
      absolute_position_data <= general_inputs & func_mask(in_func, IN_FN_ABS);
      step_mode              <= step_sh;
      m_code_off             <= moff_sh;
    end
  end

  // ----------------------------------------------------------------
  // per-axis sequencer
  // ----------------------------------------------------------------
  logic [1:0] gen_busy;
  logic [1:0] gen_req;
  logic [1:0] gen_abort;
  logic [1:0] gen_rev;
  logic [1:0][15:0] gen_cnt;
  apsc_state_e state_q [2];

  for (genvar a = 0; a < 2; a++) begin : g_axis
    logic [31:0] hold_q;
    logic [31:0] clr_q;
    logic        run_q;

    // stop wins over start and both jog inputs
    assign gen_abort[a] = stop_sh[a];

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        state_q[a]      <= APSC_IDLE;
        run_q           <= 1'b0;
        gen_req[a]      <= 1'b0;
        gen_rev[a]      <= 1'b0;
        gen_cnt[a]      <= 16'h0000;
        hold_q          <= 32'h0;
        line_advance[a] <= 1'b0;
      end else if (clk_en) begin
        gen_req[a]      <= 1'b0;
        line_advance[a] <= 1'b0;
        if (stop_sh[a]) begin
          state_q[a] <= APSC_IDLE;
          run_q      <= 1'b0;
        end else begin
          unique case (state_q[a])
            APSC_IDLE: begin
              if (auto_mode && drive_ready_in[a] && (start_sh[a] || run_q)) begin
                run_q      <= ~step_sh[a];
                state_q[a] <= APSC_FETCH;
              end else if (!auto_mode && (jf_q[a] ^ jr_q[a])) begin
                // single minimum-unit pulse first, then continuous after the hold
                gen_req[a] <= 1'b1;
                gen_rev[a] <= jr_q[a];
                gen_cnt[a] <= 16'h0001;
                hold_q     <= 32'h0;
                state_q[a] <= APSC_JOG;
              end
            end
            APSC_FETCH: begin
              line_advance[a] <= 1'b1;
              if (line_op[a] == OP_M00 || line_op[a] == OP_M02) begin
                run_q      <= 1'b0;
                state_q[a] <= APSC_IDLE;
              end else if (line_op[a] == OP_MOVE) begin
                gen_req[a] <= 1'b1;
                gen_rev[a] <= line_dir_rev[a];
                gen_cnt[a] <= line_count[a];
                state_q[a] <= APSC_MOVE;
              end else begin
                state_q[a] <= APSC_WAIT;
              end
            end
            APSC_MOVE: begin
              if (!gen_req[a] && !gen_busy[a]) begin
                state_q[a] <= APSC_WAIT;
              end
            end
            APSC_WAIT: begin
              // start edges are dropped here: the line is not finished yet
              if (drive_in_position_in[a]) begin
                state_q[a] <= APSC_IDLE;
              end
            end
            APSC_JOG: begin
              if (!(jf_q[a] ^ jr_q[a])) begin
                state_q[a] <= APSC_IDLE;
              end else if (hold_q < JOG_HOLD) begin
                hold_q <= hold_q + CNT_ONE;
              end else if (!gen_busy[a] && !gen_req[a]) begin
                gen_req[a] <= 1'b1;
                gen_cnt[a] <= 16'h0001;
              end
            end
            default: state_q[a] <= APSC_IDLE;
          endcase
        end
      end
    end

    // request stretched by a fixed tail
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        clr_q                  <= 32'h0;
        deviation_clear_out[a] <= 1'b0;
      end else if (clk_en) begin
        if (deviation_clear_req[a]) begin
          clr_q <= CLR_LEN;
        end else if (clr_q != CNT_ZERO) begin
          clr_q <= clr_q - CNT_ONE;
        end
        deviation_clear_out[a] <= deviation_clear_req[a] || (clr_q > CNT_ONE);
      end
    end

    apsc_pulse_gen u_gen (
      .clk_sys           (clk_sys),
      .rst               (rst),
      .clk_en            (clk_en),
      .req_valid         (gen_req[a]),
      .req_dir_rev       (gen_rev[a]),
      .req_count         (gen_cnt[a]),
      .abort             (gen_abort[a]),
      .busy              (gen_busy[a]),
      .forward_pulse_out (forward_pulse_out[a]),
      .reverse_pulse_out (reverse_pulse_out[a])
    );

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        running[a]                   <= 1'b0;
        positioning_complete_flag[a] <= 1'b0;
        zero_seen[a]                 <= 1'b0;
      end else if (clk_en) begin
        running[a]                   <= (state_q[a] != APSC_IDLE);
        positioning_complete_flag[a] <= drive_in_position_in[a] && !gen_busy[a];
        // marker is sticky until the axis starts a new motion
        zero_seen[a] <= zero_marker_in[a] || (zero_seen[a] && !gen_req[a]);
      end
    end
  end

  // ----------------------------------------------------------------
  // general-purpose outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      general_outputs <= 8'h00;
    end else if (clk_en) begin
      for (int i = 0; i < GP_WIDTH; i++) begin
        unique case (out_func[i])
          OUT_FN_READY: general_outputs[i] <= &drive_ready_in;
          OUT_FN_DIGIT,
          OUT_FN_MCODE,
          OUT_FN_ABS:   general_outputs[i] <= out_source[i];
          default:      general_outputs[i] <= 1'b0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### apsc_axis_ctrl_assertions.sv
// checker: port-level properties of the axis pulse step control block
`timescale 1ns/10ps
`default_nettype none
module apsc_axis_ctrl_chk
  import apsc_pkg::*;
#(
  parameter int unsigned JOG_HOLD = 50,
  parameter int unsigned CLR_LEN  = 5
) (
  // clock and reset
  input wire logic                                 clk_sys,
  input wire logic                                 rst,
  // commands and modes
  input wire logic                                 auto_mode,
  input wire logic                                 dual_axis,
  input wire logic [1:0]                           start_in,
  input wire logic [1:0]                           stop_in,
  input wire logic [1:0]                           jog_forward_in,
  input wire logic [1:0]                           jog_reverse_in,
  input wire logic [1:0]                           deviation_clear_req,
  input wire logic [1:0]                           zero_marker_in,
  input wire logic [GP_WIDTH-1:0]                  general_inputs,
  input wire logic [GP_WIDTH-1:0][FUNC_WIDTH-1:0]  in_func,
  // outputs watched
  input wire logic [1:0]                           line_advance,
  input wire logic [1:0]                           deviation_clear_out,
  input wire logic [1:0]                           forward_pulse_out,
  input wire logic [1:0]                           reverse_pulse_out,
  input wire logic [1:0]                           step_mode,
  input wire logic [1:0]                           zero_seen,
  input wire logic [1:0]                           running
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  localparam int CLR_MAX = CLR_LEN + 4;
  localparam int JOG_MAX = JOG_HOLD + 300;
  logic       step_sel;
  logic [1:0] st_q;
  logic [2:0] age_q;
  logic       ok_q;
  always_comb begin
    step_sel = 1'b0;
    for (int i = 0; i < GP_WIDTH; i++) begin
      step_sel |= general_inputs[i] && (in_func[i] == IN_FN_STEP);
    end
  end
  // age of the last x start edge, and idle state at it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q  <= 2'h0;
      age_q <= 3'h7;
      ok_q  <= 1'b0;
    end else begin
      st_q <= start_in;
      if (start_in[0] && !st_q[0]) begin
        age_q <= 3'h0;
        ok_q  <= !running[0];
      end else if (age_q != 3'h7) begin
        age_q <= age_q + 3'h1;
      end
    end
  end
  chk_step_enter: assert property (step_sel |-> ##[1:2] step_mode == 2'h3)
    else $error("step select did not enter step mode");
  chk_step_line: assert property (step_mode[0] && line_advance[0]
    && !dual_axis |-> age_q <= 3'h3 && ok_q)
    else $error("step line without a fresh idle start edge");
  chk_dual_run: assert property (dual_axis && $rose(running[0]) |-> ##[0:1] running[1])
    else $error("dual start did not reach second axis");
  chk_dual_stop: assert property (dual_axis && $rose(stop_in[1]) |->
    ##[1:4] running == 2'h0) else $error("stop on second axis did not halt both");
  chk_stop_halt: assert property ($rose(stop_in[0]) |-> ##[1:4] !running[0])
    else $error("stop edge did not halt axis");
  chk_stop_wins: assert property ($rose(stop_in[0]) && $rose(start_in[0])
    && !running[0] |=> !line_advance[0] [*4]) else $error("start beat stop");
  chk_clr_on: assert property ($rose(deviation_clear_req[0]) |->
    ##[1:2] deviation_clear_out[0]) else $error("deviation clear not driven");
  chk_clr_off: assert property (deviation_clear_out[0] && !deviation_clear_req[0]
    |-> ##[0:CLR_MAX] !deviation_clear_out[0]) else $error("deviation clear stuck");
  chk_fwd_width: assert property ($rose(forward_pulse_out[0]) |->
    forward_pulse_out[0] [*8]) else $error("forward pulse too short");
  chk_rev_width: assert property ($rose(reverse_pulse_out[1]) |->
    reverse_pulse_out[1] [*8]) else $error("reverse pulse too short");
  chk_no_both: assert property (!(|(forward_pulse_out & reverse_pulse_out)))
    else $error("forward and reverse pulses together");
  chk_jog_pulse: assert property (!auto_mode && !running[0]
    && $rose(jog_forward_in[0]) && !jog_reverse_in[0] && !stop_in[0] |-> ##[1:JOG_MAX]
    forward_pulse_out[0]) else $error("jog gave no pulse");
  chk_zero_seen: assert property ($rose(zero_marker_in[0]) |-> ##[1:2] zero_seen[0])
    else $error("zero marker not latched");
  cov_step: cover property (step_mode[0] && line_advance[0]);
  cov_dual: cover property (dual_axis && running == 2'h3);
  cov_jog: cover property (!auto_mode && reverse_pulse_out[1]);
endmodule
bind apsc_axis_ctrl apsc_axis_ctrl_chk #(.JOG_HOLD(JOG_HOLD), .CLR_LEN(CLR_LEN)) u_chk (
  .clk_sys, .rst, .auto_mode, .dual_axis, .start_in, .stop_in, .jog_forward_in,
  .jog_reverse_in, .deviation_clear_req, .zero_marker_in, .general_inputs, .in_func,
  .line_advance, .deviation_clear_out, .forward_pulse_out, .reverse_pulse_out, .step_mode,
  .zero_seen, .running);
`default_nettype wire

// ### apsc_drive_model.sv
// partner: behavioural servo drive for one axis
`timescale 1ns/10ps
`default_nettype none
module apsc_drive_model #(
  parameter int unsigned READY_DLY = 10
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // pulses in, test controls
  input  wire logic       fwd_pulse,
  input  wire logic       rev_pulse,
  input  wire logic       hold_off,
  input  wire logic [7:0] settle,
  // indications back
  output logic            ready,
  output logic            in_pos,
  output logic            marker
);
  int unsigned age_q;
  logic [7:0]  quiet_q;
  logic        fp_q;
  logic        rp_q;
  // hold_off models a drive that never finishes preparing
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      age_q <= 0;
      ready <= 1'b0;
    end else begin
      if (age_q != READY_DLY) begin
        age_q <= age_q + 1;
      end
      ready <= (age_q == READY_DLY) && !hold_off;
    end
  end
  // any pulse edge unsettles the axis; settle sets prompt or slow answer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fp_q    <= 1'b0;
      rp_q    <= 1'b0;
      quiet_q <= 8'h00;
      in_pos  <= 1'b1;
      marker  <= 1'b0;
    end else begin
      fp_q   <= fwd_pulse;
      rp_q   <= rev_pulse;
      marker <= fwd_pulse && !fp_q;
      if (fwd_pulse != fp_q || rev_pulse != rp_q) begin
        quiet_q <= 8'h00;
        in_pos  <= 1'b0;
      end else if (quiet_q < settle) begin
        quiet_q <= quiet_q + 8'h01;
      end else begin
        in_pos <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### test_axis_pulse_step_control.sv
// testbench: self-checking run of the axis pulse step control block
`timescale 1ns/10ps
`default_nettype none
module test_axis_pulse_step_control;
  import apsc_pkg::*;
  localparam int unsigned JOG_T = 50;
  localparam int unsigned CLR_T = 5;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic dual_axis = 1'b0;
  logic auto_mode = 1'b1;
  logic [1:0] start_in = 2'h0, stop_in = 2'h0, jog_forward_in = 2'h0, jog_reverse_in = 2'h0;
  logic [1:0] deviation_clear_req = 2'h0, hold_off = 2'h0, line_dir_rev = 2'h0;
  logic [1:0][OP_WIDTH-1:0] line_op = {OP_MOVE, OP_MOVE};
  logic [1:0][15:0] line_count = 32'h0001_0001;
  logic [GP_WIDTH-1:0] general_inputs = 8'h00, out_source = 8'h00;
  logic [GP_WIDTH-1:0][FUNC_WIDTH-1:0] in_func = 24'h0, out_func = 24'h0;
  logic [1:0] drive_ready_in, drive_in_position_in, zero_marker_in, line_advance, running;
  logic [1:0] deviation_clear_out, forward_pulse_out, reverse_pulse_out, step_mode, zero_seen;
  logic [1:0] m_code_off, fp_q = 2'h0, rp_q = 2'h0, pcf;
  logic [GP_WIDTH-1:0] switch_data, hwheel_data, absolute_position_data, gpo;
  logic [7:0] settle = 8'h02;
  int err_total = 0, n_checks = 0, seed = 63;
  int nf[2], nr[2], na[2];
  always #2.5 clk_sys = ~clk_sys;
  apsc_axis_ctrl #(.JOG_HOLD(JOG_T), .CLR_LEN(CLR_T)) u_dut (
    .clk_sys, .rst, .clk_en(1'b1), .dual_axis, .auto_mode, .start_in, .stop_in,
    .jog_forward_in, .jog_reverse_in, .deviation_clear_req, .line_op, .line_dir_rev,
    .line_count, .line_advance, .drive_ready_in, .drive_in_position_in, .zero_marker_in,
    .deviation_clear_out, .forward_pulse_out, .reverse_pulse_out, .general_inputs, .in_func,
    .out_func, .out_source, .general_outputs(gpo), .step_mode, .positioning_complete_flag(pcf),
    .zero_seen, .running, .m_code_off, .switch_data, .hwheel_data, .absolute_position_data);
  for (genvar a = 0; a < 2; a++) begin : g_drv
    apsc_drive_model u_drv (.clk_sys, .rst, .fwd_pulse(forward_pulse_out[a]),
      .rev_pulse(reverse_pulse_out[a]), .hold_off(hold_off[a]), .settle,
      .ready(drive_ready_in[a]), .in_pos(drive_in_position_in[a]), .marker(zero_marker_in[a]));
  end
  always @(posedge clk_sys) begin
    for (int a = 0; a < 2; a++) begin
      nf[a] += int'(forward_pulse_out[a] && !fp_q[a]);
      nr[a] += int'(reverse_pulse_out[a] && !rp_q[a]);
      na[a] += int'(line_advance[a]);
    end
    fp_q <= forward_pulse_out;
    rp_q <= reverse_pulse_out;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic clr_cnt();
    nf = '{0, 0};
    nr = '{0, 0};
    na = '{0, 0};
  endtask
  task automatic pulse_start(input int a);
    start_in[a] = 1'b1;
    tick(3);
    start_in[a] = 1'b0;
  endtask
  // bounded wait for idle
  task automatic wait_idle(input int a);
    int k;
    k = 0;
    tick(4);
    while (running[a] === 1'b1 && k < 3000) begin
      tick(1);
      k++;
    end
    chk(32'(k < 3000), 32'h1);
  endtask
  task automatic end_of_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic [31:0] exp_pulses(input logic rev, input logic want,
                                             input logic [15:0] n);
    return (rev == want) ? {16'h0000, n} : 32'h0;
  endfunction
  function automatic logic [GP_WIDTH-1:0] exp_mask(input logic [2:0] fn);
    for (int i = 0; i < GP_WIDTH; i++) begin
      exp_mask[i] = general_inputs[i] && (in_func[i] == fn);
    end
  endfunction
  initial begin
    #300000;
    err_total++;
    end_of_test();
  end
  initial begin
    logic [2:0] fns [3];
    int g;
    fns = '{IN_FN_DSW, IN_FN_HWHEEL, IN_FN_ABS};
    for (int i = 0; i < GP_WIDTH; i++) begin
      out_func[i] = 3'(i % 5);
    end
    out_source = 8'($random(seed));
    tick(2);
    rst = 1'b0;
    tick(15);
    foreach (fns[f]) begin
      general_inputs = 8'($random(seed));
      for (int i = 0; i < GP_WIDTH; i++) begin
        in_func[i] = ($random(seed) & 1) ? fns[f] : IN_FN_NONE;
      end
      tick(3);
      chk(32'(f == 0 ? switch_data : f == 1 ? hwheel_data : absolute_position_data),
          32'(exp_mask(fns[f])));
    end
    in_func = 24'h0;
    in_func[3] = IN_FN_MOFF;
    general_inputs = 8'h08;
    tick(3);
    chk(32'(m_code_off), 32'h3);
    in_func[3] = IN_FN_NONE;
    g = {$random(seed)} % 8;
    in_func[g] = IN_FN_STEP;
    general_inputs = 8'h00;
    general_inputs[g] = 1'b1;
    tick(3);
    chk(32'(step_mode), 32'h3);
    for (int r = 0; r < 4; r++) begin
      line_count[0] = 16'(1 + {$random(seed)} % 3);
      line_dir_rev[0] = r[0];
      settle = r[1] ? 8'h28 : 8'h02;
      clr_cnt();
      pulse_start(0);
      tick(150);
      pulse_start(0);
      chk(32'(pcf[0]), 32'h0);
      wait_idle(0);
      chk(na[0], 1);
      chk(nf[0], exp_pulses(line_dir_rev[0], 1'b0, line_count[0]));
      chk(nr[0], exp_pulses(line_dir_rev[0], 1'b1, line_count[0]));
      chk(32'(zero_seen[0]), 32'(!r[0]));
    end
    dual_axis = 1'b1;
    clr_cnt();
    pulse_start(1);
    wait_idle(0);
    wait_idle(1);
    chk(na[0] + na[1], 2);
    pulse_start(1);
    tick(120);
    stop_in[1] = 1'b1;
    tick(5);
    chk(32'(running), 32'h0);
    stop_in[1] = 1'b0;
    dual_axis = 1'b0;
    general_inputs = 8'h00;
    line_op[0] = OP_M00;
    clr_cnt();
    start_in[0] = 1'b1;
    stop_in[0] = 1'b1;
    tick(6);
    chk(na[0], 0);
    start_in[0] = 1'b0;
    stop_in[0] = 1'b0;
    tick(2);
    foreach (line_op[k]) begin
      line_op[0] = k ? OP_M02 : OP_M00;
      clr_cnt();
      pulse_start(0);
      wait_idle(0);
      chk(na[0], 1);
    end
    hold_off[0] = 1'b1;
    tick(3);
    clr_cnt();
    pulse_start(0);
    tick(6);
    chk(na[0], 0);
    chk(32'(gpo), 32'(out_source & 8'h5A | (&drive_ready_in ? 8'h84 : 8'h00)));
    hold_off[0] = 1'b0;
    deviation_clear_req = 2'h3;
    tick(3);
    chk(32'(deviation_clear_out), 32'h3);
    deviation_clear_req = 2'h0;
    tick(CLR_T + 6);
    chk(32'(deviation_clear_out), 32'h0);
    auto_mode = 1'b0;
    for (int j = 0; j < 4; j++) begin
      for (int h = 0; h < 2; h++) begin
        clr_cnt();
        jog_forward_in[j / 2] = !j[0];
        jog_reverse_in[j / 2] = j[0];
        tick(h ? JOG_T + 700 : 5);
        jog_forward_in = 2'h0;
        jog_reverse_in = 2'h0;
        tick(400);
        g = j[0] ? nr[j / 2] : nf[j / 2];
        chk(32'(h ? g >= 2 : g == 1), 32'h1);
      end
    end
    end_of_test();
  end
endmodule
`default_nettype wire
